// ### hw/fsir_cfg.svh
// Offsets, field positions, reset values and timing counts of the fail-safe setup registers
`ifndef FSIR_CFG_SVH
`define FSIR_CFG_SVH

// Frame layout
`define FSIR_FRAME_BITS      16
`define FSIR_BIT_WRITE       15
`define FSIR_ADDR_HI         14
`define FSIR_ADDR_LO         9
`define FSIR_BIT_PARITY      8
`define FSIR_ADDR_FAULT      6'h24
`define FSIR_ADDR_FSSM       6'h25

// Field positions inside each 4-bit register
`define FSIR_FLT_LIMIT_SEL   3
`define FSIR_FLT_CAN_EFFECT  2
`define FSIR_FLT_OUT_EFF_HI  1
`define FSIR_FLT_OUT_EFF_LO  0
`define FSIR_FSM_PAIR_B      3
`define FSIR_FSM_PAIR_A      2
`define FSIR_FSM_POLARITY    1
`define FSIR_FSM_RST_LEN     0

// Reset values, applied on power-on reset only
`define FSIR_FAULT_RESET     4'h5
`define FSIR_FSSM_RESET      4'h4

// Fault counter thresholds
`define FSIR_INTER_NORMAL    3'h3
`define FSIR_FINAL_NORMAL    3'h6
`define FSIR_INTER_FAST      3'h1
`define FSIR_FINAL_FAST      3'h2

// Reset pulse timing at a 25 ns clock
`define FSIR_CLK_PERIOD_NS   25
`define FSIR_RST_LONG_MS     10
`define FSIR_RST_SHORT_US    1000
`define FSIR_RST_LONG_CYC    ((`FSIR_RST_LONG_MS * 1000000) / `FSIR_CLK_PERIOD_NS)
`define FSIR_RST_SHORT_CYC   ((`FSIR_RST_SHORT_US * 1000) / `FSIR_CLK_PERIOD_NS)

`endif

// ### hw/fsir_pkg.sv
// Types shared by the fail-safe setup register block
`default_nettype none
package fsir_pkg;
   typedef logic [3:0]  fsir_field_t;
   typedef logic [15:0] fsir_frame_t;
   typedef enum logic {FSIR_RST_IDLE, FSIR_RST_LOW} fsir_rst_e;
endpackage
`default_nettype wire

// ### hw/fsir_spi_link.sv
// Serial link end of the register block, clocked by the host's serial clock
`timescale 1ns/1ps
`default_nettype none
`include "fsir_cfg.svh"
module fsir_spi_link (
   // Serial pins
   input  wire logic               spi_sclk_i,
   input  wire logic               spi_cs_n_i,
   input  wire logic               spi_mosi_i,
   output logic                    spi_miso_o,
   output logic                    spi_miso_oe_n_o,
   // Quasi-static data from the system side
   input  wire fsir_pkg::fsir_frame_t tx_word_i,
   input  wire fsir_pkg::fsir_field_t fault_field_i,
   input  wire fsir_pkg::fsir_field_t fssm_field_i,
   // Last frame, stable while chip select is high
   output fsir_pkg::fsir_frame_t   rx_word_o,
   output logic [4:0]              rx_count_o
);
   import fsir_pkg::*;

   logic        armed_q, armed_d;
   logic        ran_q;
   logic [4:0]  cnt_q, cnt_d;
   fsir_frame_t sh_q, sh_d;
   logic [5:0]  addr_q, addr_d;
   logic        out_q, out_d;
   logic [4:0]  idx;
   fsir_field_t nib;

   // Shift in on rising edges; first edge of a frame restarts the count
   always_comb begin
      armed_d = 1'b0;
      if (armed_q) begin
         cnt_d = 5'h01;
         sh_d  = {15'h0000, spi_mosi_i};
      end else begin
         cnt_d = (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
         sh_d  = {sh_q[14:0], spi_mosi_i};
      end
      addr_d = (cnt_d == 5'h07) ? sh_d[5:0] : addr_q;
   end

   // Chip select high rearms; the clock may stand still between frames
   always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) begin
         armed_q <= 1'b1;
      end else begin
         armed_q <= armed_d;
      end
   end

   always_ff @(posedge spi_sclk_i) begin
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      addr_q <= addr_d;
   end

   // Field nibble picked by the address seen earlier in the same frame
   always_comb begin
      idx = 5'h0f - cnt_q;
      if (addr_q == `FSIR_ADDR_FAULT) begin
         nib = fault_field_i;
      end else if (addr_q == `FSIR_ADDR_FSSM) begin
         nib = fssm_field_i;
      end else begin
         nib = 4'h0;
      end
      if (cnt_q > 5'h0f) begin
         out_d = 1'b0;
      end else if (cnt_q > 5'h0b) begin
         out_d = nib[idx[1:0]];
      end else begin
         out_d = tx_word_i[idx[3:0]];
      end
   end

   always_ff @(negedge spi_sclk_i) begin
      out_q <= out_d;
   end

   always_ff @(negedge spi_sclk_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) begin
         ran_q <= 1'b0;
      end else begin
         ran_q <= 1'b1;
      end
   end

   // Bit 15 must stand before the first falling edge
   assign spi_miso_o      = ran_q ? out_q : tx_word_i[15];
   assign spi_miso_oe_n_o = spi_cs_n_i;
   assign rx_word_o       = sh_q;
   assign rx_count_o      = cnt_q;
endmodule
`default_nettype wire

// ### hw/fsir_top.sv
// Fail-safe setup registers with their serial access and the outputs they steer
//
// How it works
// - The limit select bit picks fault thresholds 3 and 6 when clear, 1 and 2 when set.
// - With the CAN effect bit set, a low secondary fail-safe puts CAN in receive-only or sleep.
// - Output effect 00 leaves reset and primary fail-safe alone at the intermediate count.
// - Output effect 01 or 11 drives primary fail-safe low at or above the intermediate count.
// - Output effect 10 or 11 pulls reset low when that count is reached and the watchdog is at its limit.
// - A set pair B bit makes IO lines 4 and 5 safety inputs for an external chip.
// - A set pair A bit, the default, makes IO lines 2 and 3 safety inputs for the fault unit.
// - The polarity bit makes the fault unit inputs active high when clear, active low when set.
// - Each reset assertion lasts 10 ms with the length bit clear and 1.0 ms with it set.
`timescale 1ns/1ps
`default_nettype none
`include "fsir_cfg.svh"
module fsir_top #(
   parameter int RST_LONG_CYCLES  = `FSIR_RST_LONG_CYC,
   parameter int RST_SHORT_CYCLES = `FSIR_RST_SHORT_CYC
) (
   // System clock and power-on reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  reset_n_i,
   input  wire logic                  ce_i,
   // Serial link
   input  wire logic                  spi_sclk_i,
   input  wire logic                  spi_cs_n_i,
   input  wire logic                  spi_mosi_i,
   output logic                       spi_miso_o,
   output logic                       spi_miso_oe_n_o,
   // Status flags shown on every frame
   input  wire logic [7:0]            global_flags_i,
   // Fault and watchdog counters
   input  wire logic [2:0]            fault_error_counter_i,
   input  wire logic [1:0]            watchdog_error_count_i,
   input  wire logic [1:0]            watchdog_error_limit_i,
   output logic [2:0]                 fault_inter_limit_o,
   output logic [2:0]                 fault_final_limit_o,
   // Fail-safe and reset pins
   output logic                       primary_failsafe_output_n_o,
   output logic                       system_reset_pin_n_o,
   // CAN transceiver control
   input  wire logic                  secondary_failsafe_output_n_i,
   input  wire logic                  can_disable_choice_i,
   output logic                       can_rx_only_o,
   output logic                       can_sleep_o,
   // Safety inputs on IO pairs
   input  wire logic [1:0]            fcu_error_pin_i,
   input  wire logic [1:0]            ext_error_pin_i,
   output logic [1:0]                 fcu_error_o,
   output logic [1:0]                 ext_error_o,
   output logic                       io_pair_a_safety_o,
   output logic                       io_pair_b_safety_o
);
   import fsir_pkg::*;

   localparam int SYNC_W = 5;
   localparam logic [18:0] LONG_C  = RST_LONG_CYCLES[18:0];
   localparam logic [18:0] SHORT_C = RST_SHORT_CYCLES[18:0];

   fsir_field_t       fault_q, fault_d;
   fsir_field_t       fssm_q, fssm_d;
   logic [3:0]        err_q, err_d;
   fsir_frame_t       txw_q, txw_d;
   logic [SYNC_W-1:0] sync1_q, sync2_q;
   logic              cs_prev_q;
   fsir_rst_e         rst_st_q, rst_st_d;
   logic [18:0]       rst_cnt_q, rst_cnt_d;
   logic              req_prev_q;
   logic              pfs_n_q, pfs_n_d;
   logic              can_rx_q, can_rx_d, can_sl_q, can_sl_d;
   logic [1:0]        fcu_q, fcu_d, ext_q, ext_d;

   fsir_frame_t       rx_word;
   logic [4:0]        rx_count;
   logic              frame_end, wr, is_fault, is_fssm;
   logic              clk_err, req_err, par_err, sec_err;
   logic [5:0]        addr;
   logic              at_inter, rst_req;

   fsir_spi_link u_link (
      .spi_sclk_i      (spi_sclk_i),
      .spi_cs_n_i      (spi_cs_n_i),
      .spi_mosi_i      (spi_mosi_i),
      .spi_miso_o      (spi_miso_o),
      .spi_miso_oe_n_o (spi_miso_oe_n_o),
      .tx_word_i       (txw_q),
      .fault_field_i   (fault_q),
      .fssm_field_i    (fssm_q),
      .rx_word_o       (rx_word),
      .rx_count_o      (rx_count)
   );

   // Two-stage synchronisers for chip select and the error pins
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         // Idle levels, so no false error edge follows reset
         sync1_q   <= {1'b1, {(SYNC_W-1){1'b0}}};
         sync2_q   <= {1'b1, {(SYNC_W-1){1'b0}}};
         cs_prev_q <= 1'b1;
      end else if (ce_i) begin
         sync1_q   <= {spi_cs_n_i, fcu_error_pin_i, ext_error_pin_i};
         sync2_q   <= sync1_q;
         cs_prev_q <= sync2_q[4];
      end
   end

   // Link words are only read after chip select is seen high again
   assign frame_end = sync2_q[4] && !cs_prev_q;

   // Frame decode and checks
   always_comb begin
      wr       = rx_word[`FSIR_BIT_WRITE];
      addr     = rx_word[`FSIR_ADDR_HI:`FSIR_ADDR_LO];
      is_fault = (addr == `FSIR_ADDR_FAULT);
      is_fssm  = (addr == `FSIR_ADDR_FSSM);
      clk_err  = (rx_count != 5'h10);
      req_err  = !(is_fault || is_fssm) || (!wr && (rx_word[8:0] != 9'h000));
      par_err  = wr && !(^rx_word);
      // Secure bits are checked, not trusted
      sec_err  = wr && (rx_word[3:0] != {~rx_word[5], ~rx_word[4], rx_word[7], rx_word[6]});
      fault_d  = fault_q;
      fssm_d   = fssm_q;
      err_d    = err_q;
      if (frame_end) begin
         err_d = {sec_err, clk_err, req_err, par_err};
         if (wr && !clk_err && !req_err && !par_err && !sec_err) begin
            if (is_fault) begin
               fault_d = rx_word[7:4];
            end else begin
               fssm_d = rx_word[7:4];
            end
         end
      end
      // Frozen while a frame runs so the link sees a steady word
      txw_d = sync2_q[4] ? {global_flags_i, err_q, 4'h0} : txw_q;
   end

   // The only reset of this block is power-on
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         fault_q <= `FSIR_FAULT_RESET;
         fssm_q  <= `FSIR_FSSM_RESET;
         err_q   <= 4'h0;
         txw_q   <= 16'h0000;
      end else if (ce_i) begin
         fault_q <= fault_d;
         fssm_q  <= fssm_d;
         err_q   <= err_d;
         txw_q   <= txw_d;
      end
   end

   // Thresholds and fault effects
   always_comb begin
      if (fault_q[`FSIR_FLT_LIMIT_SEL]) begin
         fault_inter_limit_o = `FSIR_INTER_FAST;
         fault_final_limit_o = `FSIR_FINAL_FAST;
      end else begin
         fault_inter_limit_o = `FSIR_INTER_NORMAL;
         fault_final_limit_o = `FSIR_FINAL_NORMAL;
      end
      at_inter = (fault_error_counter_i >= fault_inter_limit_o);
      // Effect 00 sets neither term below
      pfs_n_d  = !(fault_q[`FSIR_FLT_OUT_EFF_LO] && at_inter);
      rst_req  = fault_q[`FSIR_FLT_OUT_EFF_HI] && at_inter
                 && (watchdog_error_count_i == watchdog_error_limit_i);
      can_rx_d = fault_q[`FSIR_FLT_CAN_EFFECT] && !secondary_failsafe_output_n_i
                 && !can_disable_choice_i;
      can_sl_d = fault_q[`FSIR_FLT_CAN_EFFECT] && !secondary_failsafe_output_n_i
                 && can_disable_choice_i;
   end

   // Safety inputs, one lane per pin of each pair
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_lane
         always_comb begin
            fcu_d[g] = fssm_q[`FSIR_FSM_PAIR_A]
                       && (sync2_q[2+g] ^ fssm_q[`FSIR_FSM_POLARITY]);
            ext_d[g] = fssm_q[`FSIR_FSM_PAIR_B] && sync2_q[g];
         end
      end
   endgenerate

   // Reset pulse: a new request starts a timed low phase
   always_comb begin
      rst_st_d  = rst_st_q;
      rst_cnt_d = rst_cnt_q;
      case (rst_st_q)
         FSIR_RST_IDLE: begin
            if (rst_req && !req_prev_q) begin
               rst_st_d  = FSIR_RST_LOW;
               rst_cnt_d = (fssm_q[`FSIR_FSM_RST_LEN] ? SHORT_C : LONG_C) - 19'h00001;
            end
         end
         FSIR_RST_LOW: begin
            if (rst_cnt_q == 19'h00000) begin
               rst_st_d = FSIR_RST_IDLE;
            end else begin
               rst_cnt_d = rst_cnt_q - 19'h00001;
            end
         end
         default: rst_st_d = FSIR_RST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         rst_st_q   <= FSIR_RST_IDLE;
         rst_cnt_q  <= 19'h00000;
         req_prev_q <= 1'b0;
         pfs_n_q    <= 1'b1;
         can_rx_q   <= 1'b0;
         can_sl_q   <= 1'b0;
         fcu_q      <= 2'h0;
         ext_q      <= 2'h0;
      end else if (ce_i) begin
         rst_st_q   <= rst_st_d;
         rst_cnt_q  <= rst_cnt_d;
         req_prev_q <= rst_req;
         pfs_n_q    <= pfs_n_d;
         can_rx_q   <= can_rx_d;
         can_sl_q   <= can_sl_d;
         fcu_q      <= fcu_d;
         ext_q      <= ext_d;
      end
   end

   assign primary_failsafe_output_n_o = pfs_n_q;
   assign system_reset_pin_n_o        = (rst_st_q != FSIR_RST_LOW);
   assign can_rx_only_o               = can_rx_q;
   assign can_sleep_o                 = can_sl_q;
   assign fcu_error_o                 = fcu_q;
   assign ext_error_o                 = ext_q;
   assign io_pair_a_safety_o          = fssm_q[`FSIR_FSM_PAIR_A];
   assign io_pair_b_safety_o          = fssm_q[`FSIR_FSM_PAIR_B];
endmodule
`default_nettype wire

// ### verif/fsir_spi_host.sv
// Serial host model issuing frames of a chosen bit count to the register block
`timescale 1ns/1ps
`default_nettype none
module fsir_spi_host (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   initial begin
      sclk_o = 1'b0;
      mosi_o = 1'b0;
      // Late rise gives the link a clean rearm edge
      #1 cs_n_o = 1'b1;
   end
   function automatic logic [15:0] wr_word(input logic [5:0] a, input logic [3:0] d);
      logic [15:0] w;
      w = {1'b1, a, 1'b0, d, ~d[1], ~d[0], d[3], d[2]};
      w[8] = ~^w;
      return w;
   endfunction
   // Clock runs only inside a frame; released data line flips
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0;
      cs_n_o = 1'b0;
      #110;
      for (int i = 15; i > 15 - n; i--) begin
         mosi_o = w[i];
         #3 sclk_o = 1'b1;
         r[i] = miso_i;
         #3 sclk_o = 1'b0;
      end
      #3 mosi_o = ~mosi_o;
      cs_n_o = 1'b1;
      #140;
   endtask
endmodule
`default_nettype wire

// ### verif/fsir_top_monitor.sv
// Concurrent checks on the fail-safe setup register block ports
`timescale 1ns/1ps
`default_nettype none
module fsir_top_monitor #(
   parameter int RST_LONG_CYCLES  = 40,
   parameter int RST_SHORT_CYCLES = 4
) (
   input wire logic       sys_clk_i,
   input wire logic       reset_n_i,
   input wire logic       spi_cs_n_i,
   input wire logic       spi_miso_oe_n_o,
   input wire logic [2:0] fault_error_counter_i,
   input wire logic [1:0] watchdog_error_count_i,
   input wire logic [1:0] watchdog_error_limit_i,
   input wire logic [2:0] fault_inter_limit_o,
   input wire logic [2:0] fault_final_limit_o,
   input wire logic       primary_failsafe_output_n_o,
   input wire logic       system_reset_pin_n_o,
   input wire logic       secondary_failsafe_output_n_i,
   input wire logic       can_rx_only_o,
   input wire logic       can_sleep_o,
   input wire logic [1:0] fcu_error_o,
   input wire logic [1:0] ext_error_o,
   input wire logic       io_pair_a_safety_o,
   input wire logic       io_pair_b_safety_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   logic        wd_hit;
   logic        flt_hit;
   logic [19:0] low_cnt_q;
   logic [19:0] low_cnt_d;
   assign wd_hit  = watchdog_error_count_i == watchdog_error_limit_i;
   assign flt_hit = fault_error_counter_i >= fault_inter_limit_o;
   // Length of the current reset pulse in system cycles
   always_comb begin
      low_cnt_d = (!reset_n_i || system_reset_pin_n_o) ? 20'h0 : low_cnt_q + 20'h1;
   end
   always_ff @(posedge sys_clk_i) begin
      low_cnt_q <= low_cnt_d;
   end
   a_miso_drive: assert property (spi_miso_oe_n_o == spi_cs_n_i)
      else $error("miso enable differs from chip select");
   a_limit_pair: assert property ((fault_inter_limit_o == 3'h3 && fault_final_limit_o == 3'h6) ||
      (fault_inter_limit_o == 3'h1 && fault_final_limit_o == 3'h2))
      else $error("fault thresholds not a legal pair");
   a_primary_cause: assert property (!primary_failsafe_output_n_o |-> $past(flt_hit))
      else $error("primary fail-safe low below intermediate count");
   a_reset_cause: assert property ($fell(system_reset_pin_n_o) |-> $past(flt_hit) && $past(wd_hit))
      else $error("reset pulse without both conditions");
   a_pulse_len: assert property ($rose(system_reset_pin_n_o) |->
      low_cnt_q == RST_LONG_CYCLES || low_cnt_q == RST_SHORT_CYCLES)
      else $error("reset pulse of wrong length");
   a_pulse_bound: assert property (low_cnt_q <= RST_LONG_CYCLES)
      else $error("reset pulse too long");
   a_can_quiet: assert property (secondary_failsafe_output_n_i [*2] |->
      !can_rx_only_o && !can_sleep_o)
      else $error("CAN restricted while secondary fail-safe idle");
   a_can_onehot: assert property (!(can_rx_only_o && can_sleep_o))
      else $error("CAN receive-only and sleep together");
   a_pair_a_gate: assert property (!io_pair_a_safety_o [*2] |-> fcu_error_o == 2'h0)
      else $error("fault unit error while pair A not safety");
   a_pair_b_gate: assert property (!io_pair_b_safety_o [*2] |-> ext_error_o == 2'h0)
      else $error("external error while pair B not safety");
   c_primary: cover property ($fell(primary_failsafe_output_n_o));
   c_reset: cover property ($rose(system_reset_pin_n_o));
   c_sleep: cover property ($rose(can_sleep_o));
endmodule
bind fsir_top fsir_top_monitor #(
   .RST_LONG_CYCLES(RST_LONG_CYCLES), .RST_SHORT_CYCLES(RST_SHORT_CYCLES)
) u_mon (.sys_clk_i, .reset_n_i, .spi_cs_n_i, .spi_miso_oe_n_o, .fault_error_counter_i,
   .watchdog_error_count_i, .watchdog_error_limit_i, .fault_inter_limit_o,
   .fault_final_limit_o, .primary_failsafe_output_n_o, .system_reset_pin_n_o,
   .secondary_failsafe_output_n_i, .can_rx_only_o, .can_sleep_o, .fcu_error_o,
   .ext_error_o, .io_pair_a_safety_o, .io_pair_b_safety_o);
`default_nettype wire

// ### verif/fsir_top_tb.sv
// Self-checking bench for the fail-safe setup register block
`timescale 1ns/1ps
`default_nettype none
`include "fsir_cfg.svh"
module fsir_top_tb;
   import fsir_pkg::*;
   localparam int LONG_C  = 40;
   localparam int SHORT_C = 8;
   logic        sys_clk_i, reset_n_i, sclk, cs_n, mosi, miso, miso_d, miso_oe_n;
   logic        fs0, rst_pin, sec_n, can_dis, rx_only, sleep, pa, pb, ce;
   logic [7:0]  flags;
   logic [2:0]  flt_cnt, inter, final_l;
   logic [1:0]  wd_cnt, wd_lim, fcu_pin, ext_pin, fcu_err, ext_err;
   fsir_frame_t rd;
   int          num_errors, total_checks;
   assign miso = miso_oe_n ? ~miso_d : miso_d;
   fsir_spi_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
   fsir_top #(.RST_LONG_CYCLES(LONG_C), .RST_SHORT_CYCLES(SHORT_C)) DUT (
      .sys_clk_i, .reset_n_i, .ce_i(ce), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
      .spi_mosi_i(mosi), .spi_miso_o(miso_d), .spi_miso_oe_n_o(miso_oe_n),
      .global_flags_i(flags), .fault_error_counter_i(flt_cnt), .watchdog_error_count_i(wd_cnt),
      .watchdog_error_limit_i(wd_lim), .fault_inter_limit_o(inter),
      .fault_final_limit_o(final_l), .primary_failsafe_output_n_o(fs0),
      .system_reset_pin_n_o(rst_pin), .secondary_failsafe_output_n_i(sec_n),
      .can_disable_choice_i(can_dis), .can_rx_only_o(rx_only), .can_sleep_o(sleep),
      .fcu_error_pin_i(fcu_pin), .ext_error_pin_i(ext_pin), .fcu_error_o(fcu_err),
      .ext_error_o(ext_err), .io_pair_a_safety_o(pa), .io_pair_b_safety_o(pb));
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic wr(input logic [5:0] a, input logic [3:0] d);
      host.xfer(host.wr_word(a, d), 16, rd);
      step(1);
   endtask
   // Field and status compare; error flags only under mask m
   task automatic rdq(input logic [5:0] a, input logic [3:0] exp, input logic [3:0] m,
                      input logic [3:0] ev);
      host.xfer({1'b0, a, 9'h0}, 16, rd);
      step(1);
      check(16'({rd[15:8], rd[3:0]}), 16'({flags, exp}));
      check(16'(rd[7:4] & m), 16'(ev));
   endtask
   task automatic t_reset;
      check(16'({inter, final_l, pa, pb, fs0, rst_pin, rx_only, sleep}),
            16'({3'h3, 3'h6, 6'b101100}));
      rdq(`FSIR_ADDR_FAULT, `FSIR_FAULT_RESET, 4'hf, 4'h0);
      rdq(`FSIR_ADDR_FSSM, `FSIR_FSSM_RESET, 4'hf, 4'h0);
      $display("t_reset done");
   endtask
   task automatic t_write;
      logic [15:0] good;
      logic [15:0] w [5];
      int          n [5];
      logic [3:0]  m [5];
      good = host.wr_word(`FSIR_ADDR_FAULT, 4'ha);
      w = '{good ^ 16'h0100, good ^ 16'h0003, good, host.wr_word(6'h26, 4'ha),
            {1'b0, `FSIR_ADDR_FAULT, 9'h001}};
      n = '{16, 16, 15, 16, 16};
      m = '{4'h1, 4'h8, 4'h4, 4'h2, 4'h2};
      wr(`FSIR_ADDR_FAULT, 4'h9);
      rdq(`FSIR_ADDR_FAULT, 4'h9, 4'hf, 4'h0);
      check(16'({inter, final_l}), 16'({3'h1, 3'h2}));
      for (int i = 0; i < 5; i++) begin
         host.xfer(w[i], n[i], rd);
         step(1);
         rdq(`FSIR_ADDR_FAULT, 4'h9, m[i], m[i]);
      end
      rdq(6'h26, 4'h0, 4'hf, 4'h0);
      check(16'(fs0), 16'h1);
      flt_cnt = 3'h1;
      step(3);
      check(16'(fs0), 16'h0);
      flt_cnt = 3'h0;
      step(3);
      $display("t_write done");
   endtask
   task automatic t_io;
      logic [5:0] e;
      fcu_pin = 2'b01;
      ext_pin = 2'b10;
      for (int v = 0; v < 16; v += 2) begin
         wr(`FSIR_ADDR_FSSM, v[3:0]);
         step(5);
         e = {v[3], v[2], v[2] ? (v[1] ? 2'b10 : 2'b01) : 2'b00, v[3] ? 2'b10 : 2'b00};
         check(16'({pb, pa, fcu_err, ext_err}), 16'(e));
      end
      $display("t_io done");
   endtask
   task automatic t_can;
      wr(`FSIR_ADDR_FAULT, 4'h4);
      // Frozen clock enable must hold the CAN outputs
      ce = 1'b0;
      sec_n = 1'b0;
      step(3);
      check(16'({rx_only, sleep}), 16'h0);
      ce = 1'b1;
      for (int c = 0; c < 2; c++) begin
         can_dis = c[0];
         step(3);
         check(16'({rx_only, sleep}), (c == 0) ? 16'h2 : 16'h1);
      end
      wr(`FSIR_ADDR_FAULT, 4'h0);
      step(3);
      check(16'({rx_only, sleep}), 16'h0);
      sec_n = 1'b1;
      $display("t_can done");
   endtask
   task automatic t_fault;
      int k;
      for (int e = 0; e < 4; e++) begin
         if (e == 3) wr(`FSIR_ADDR_FSSM, 4'h5);
         wr(`FSIR_ADDR_FAULT, e[3:0]);
         flt_cnt = 3'h2;
         step(3);
         check(16'(fs0), 16'h1);
         flt_cnt = 3'h3;
         step(3);
         check(16'({fs0, rst_pin}), 16'({~e[0], 1'b1}));
         wd_cnt = 2'h2;
         k = 0;
         step(1);
         while (!rst_pin && k < 100) begin
            k++;
            step(1);
         end
         check(16'(k), 16'(e[1] ? ((e == 3) ? SHORT_C : LONG_C) : 0));
         step(5);
         check(16'(rst_pin), 16'h1);
         flt_cnt = 3'h0;
         wd_cnt = 2'h0;
         step(3);
      end
      $display("t_fault done");
   endtask
   task automatic t_por;
      reset_n_i = 1'b0;
      step(2);
      reset_n_i = 1'b1;
      step(4);
      rdq(`FSIR_ADDR_FAULT, `FSIR_FAULT_RESET, 4'hf, 4'h0);
      rdq(`FSIR_ADDR_FSSM, `FSIR_FSSM_RESET, 4'hf, 4'h0);
      $display("t_por done");
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      end_of_test;
   end
   initial begin
      reset_n_i = 1'b0;
      flags = 8'ha5;
      {flt_cnt, wd_cnt, fcu_pin, ext_pin, can_dis} = '0;
      wd_lim = 2'h2;
      ce = 1'b1;
      sec_n = 1'b1;
      num_errors = 0;
      total_checks = 0;
      step(2);
      reset_n_i = 1'b1;
      step(4);
      t_reset;
      t_write;
      t_io;
      t_can;
      t_fault;
      t_por;
      end_of_test;
   end
endmodule
`default_nettype wire
